// ### verilog/lstw_defines.vh
// Constants for the list step trigger and wait timing block
`ifndef LSTW_DEFINES_VH
`define LSTW_DEFINES_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define LSTW_REG_CTRL 8'h00
`define LSTW_REG_SAMP 8'h04
`define LSTW_REG_PULSE 8'h08
`define LSTW_REG_WAIT 8'h0c
`define LSTW_REG_STEP 8'h10
`define LSTW_REG_STAT 8'h14
`define LSTW_REG_ERR 8'h18

// ****************************************************
// Field positions and step codes
// ****************************************************
`define LSTW_CTRL_CLEAR 0
`define LSTW_PULSE_POL 31
`define LSTW_STEP_HIGH 2'h1
`define LSTW_STEP_LOW 2'h2
`define LSTW_STEP_PULSE 2'h3

// ****************************************************
// Error codes, magnitude only
// ****************************************************
`define LSTW_ERR_CMD 8'h64
`define LSTW_ERR_CONFLICT 8'hdd

// ****************************************************
// Timing in microseconds, clock rate in MHz
// ****************************************************
`define LSTW_CLK_MHZ 10
`define LSTW_TIME_MIN_US 250
`define LSTW_TIME_MAX_US 34000
`define LSTW_FILTER_US 400
`define LSTW_FILTER_CYC (`LSTW_FILTER_US * `LSTW_CLK_MHZ)

// Durations are stored as cycle counts
`define LSTW_CYC_MIN (`LSTW_TIME_MIN_US * `LSTW_CLK_MHZ)
`define LSTW_CYC_MAX (`LSTW_TIME_MAX_US * `LSTW_CLK_MHZ)

`endif

// ### verilog/lstw_top.v
// List step trigger and wait timing engine with AXI4-Lite registers
// Overview of operation
// - Sample duration accepted only within range
// - Second sample setting posts error 100
// - Sample query without setting posts error
// - Trigger setup stores width and polarity
// - Flag transistor acts as trigger until clear
// - Polarity selects conduct or off during pulse
// - Width query without setting posts error
// - Wait timeout accepted within range
// - Zero timeout means wait forever
// - Timeout query returns value or zero
// - Wait high ends on high or timeout
// - Wait low ends only on low
// - Trigger step emits one configured pulse
// - High then low steps follow external edge
// - Input stable 0.4 ms before use
// - Pulse step without width posts 221
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "lstw_defines.vh"

module lstw_top #(
	parameter FILTER_CYC = `LSTW_FILTER_CYC,
	parameter CYC_MIN = `LSTW_CYC_MIN,
	parameter CYC_MAX = `LSTW_CYC_MAX
) (
	input wire clk_sys,
	input wire rstn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire trigger_in,
	input wire output_off_flag,
	output reg flag_transistor_on,
	output reg step_done
);

	localparam ST_IDLE = 2'h0;
	localparam ST_HIGH = 2'h1;
	localparam ST_LOW = 2'h2;
	localparam ST_PULSE = 2'h3;

	// ****************************************************
	// Stored settings
	// ****************************************************
	reg [19:0] samp_cyc;
	reg samp_set;
	reg [19:0] pulse_cyc;
	reg pulse_set;
	reg pulse_pol;
	reg trig_mode;
	reg [19:0] wait_cyc;
	reg [7:0] err_code;
	reg err_valid;

	// ****************************************************
	// Input filter and step engine
	// ****************************************************
	reg trig_last;
	reg [15:0] filt_cnt;
	reg trig_stable;
	reg [1:0] state;
	reg [19:0] step_cnt;
	reg pulse_active;
	reg step_start;
	reg [1:0] step_kind;

	// ****************************************************
	// Bus handshake
	// ****************************************************
	reg [7:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire [19:0] wr_val = w_data[19:0];
	wire in_range = (wr_val >= CYC_MIN[19:0]) && (wr_val <= CYC_MAX[19:0]);
	wire full_word = (w_strb == 4'hf);

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
				`LSTW_REG_CTRL, `LSTW_REG_SAMP, `LSTW_REG_PULSE, `LSTW_REG_WAIT,
				`LSTW_REG_STEP, `LSTW_REG_ERR: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Settings, command checks and error posting
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			samp_cyc <= 20'h00000;
			samp_set <= 1'b0;
			pulse_cyc <= 20'h00000;
			pulse_set <= 1'b0;
			pulse_pol <= 1'b0;
			trig_mode <= 1'b0;
			wait_cyc <= 20'h00000;
			err_code <= 8'h00;
			err_valid <= 1'b0;
			step_start <= 1'b0;
			step_kind <= 2'h0;
		end else begin
			step_start <= 1'b0;
			if (do_write && full_word) begin
				case (aw_addr)
				`LSTW_REG_CTRL: begin
					if (w_data[`LSTW_CTRL_CLEAR]) begin
						trig_mode <= 1'b0;
						pulse_set <= 1'b0;
						wait_cyc <= 20'h00000;
					end
				end
				`LSTW_REG_SAMP: begin
					if (samp_set) begin
						err_code <= `LSTW_ERR_CMD;
						err_valid <= 1'b1;
					end else if (in_range) begin
						samp_cyc <= wr_val;
						samp_set <= 1'b1;
					end else begin
						err_code <= `LSTW_ERR_CMD;
						err_valid <= 1'b1;
					end
				end
				`LSTW_REG_PULSE: begin
					if (in_range) begin
						pulse_cyc <= wr_val;
						pulse_pol <= w_data[`LSTW_PULSE_POL];
						pulse_set <= 1'b1;
						trig_mode <= 1'b1;
					end else begin
						err_code <= `LSTW_ERR_CMD;
						err_valid <= 1'b1;
					end
				end
				`LSTW_REG_WAIT: begin
					if (in_range) begin
						wait_cyc <= wr_val;
					end else begin
						err_code <= `LSTW_ERR_CMD;
						err_valid <= 1'b1;
					end
				end
				`LSTW_REG_STEP: begin
					if (w_data[1:0] == `LSTW_STEP_PULSE && !pulse_set) begin
						err_code <= `LSTW_ERR_CONFLICT;
						err_valid <= 1'b1;
					end else if (w_data[1:0] != 2'h0 && state == ST_IDLE) begin
						step_start <= 1'b1;
						step_kind <= w_data[1:0];
					end
				end
				`LSTW_REG_ERR: begin
					err_valid <= 1'b0;
					err_code <= 8'h00;
				end
				default: begin
				end
				endcase
			end
			// A query of an unset duration posts an error; it wins over a clear
			if (s_axi_arvalid && s_axi_arready) begin
				if ((s_axi_araddr == `LSTW_REG_SAMP && !samp_set) ||
					(s_axi_araddr == `LSTW_REG_PULSE && !pulse_set)) begin
					err_code <= `LSTW_ERR_CMD;
					err_valid <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// Trigger input noise filter
	// ****************************************************
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			trig_last <= 1'b0;
			filt_cnt <= 16'h0000;
			trig_stable <= 1'b0;
		end else begin
			trig_last <= trigger_in;
			if (trigger_in != trig_last) begin
				filt_cnt <= 16'h0000;
			end else if (filt_cnt < FILTER_CYC[15:0] - 16'h0001) begin
				filt_cnt <= filt_cnt + 16'h0001;
			end else begin
				trig_stable <= trig_last;
			end
		end
	end

	// ****************************************************
	// Step engine
	// ****************************************************
	wire timed_out = (wait_cyc != 20'h00000) && (step_cnt >= wait_cyc - 20'h00001);

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			step_cnt <= 20'h00000;
			pulse_active <= 1'b0;
			step_done <= 1'b0;
		end else begin
			step_done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (step_start) begin
					state <= step_kind;
					step_cnt <= 20'h00000;
					pulse_active <= (step_kind == ST_PULSE);
				end
			end
			ST_HIGH: begin
				step_cnt <= step_cnt + 20'h00001;
				if (trig_stable || timed_out) begin
					state <= ST_IDLE;
					step_done <= 1'b1;
				end
			end
			ST_LOW: begin
				// High step before low step gives edge-paced advance
				if (!trig_stable) begin
					state <= ST_IDLE;
					step_done <= 1'b1;
				end
			end
			ST_PULSE: begin
				step_cnt <= step_cnt + 20'h00001;
				if (step_cnt >= pulse_cyc - 20'h00001) begin
					pulse_active <= 1'b0;
					state <= ST_IDLE;
					step_done <= 1'b1;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Normal duty shows the output-off flag; trigger duty shows the pulse
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flag_transistor_on <= 1'b0;
		end else if (trig_mode) begin
			flag_transistor_on <= pulse_active ? pulse_pol : !pulse_pol;
		end else begin
			flag_transistor_on <= output_off_flag;
		end
	end

	// ****************************************************
	// Read channel
	// ****************************************************
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
				`LSTW_REG_CTRL: s_axi_rdata <= {31'h00000000, trig_mode};
				`LSTW_REG_SAMP: s_axi_rdata <= {12'h000, samp_cyc};
				`LSTW_REG_PULSE: s_axi_rdata <= {pulse_pol, 11'h000, pulse_cyc};
				`LSTW_REG_WAIT: s_axi_rdata <= {12'h000, wait_cyc};
				`LSTW_REG_STEP: s_axi_rdata <= {30'h00000000, state};
				`LSTW_REG_STAT: s_axi_rdata <= {26'h0000000, trig_stable, pulse_active,
					pulse_set, samp_set, flag_transistor_on, trig_mode};
				`LSTW_REG_ERR: s_axi_rdata <= {23'h000000, err_valid, err_code};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // lstw_top

// ### tb/lstw_instr.sv
// Trigger line model of the external measuring instrument
`timescale 1ns/100ps
module lstw_instr (
	input wire clk_sys,
	input wire want,
	input wire [7:0] lag,
	output reg trigger_in
);
	reg [7:0] cnt;
	initial begin
		trigger_in = 1'b0;
		cnt = 8'h00;
	end
	// A slow instrument answers late; the level then stays until asked again
	always @(posedge clk_sys) begin
		if (want == trigger_in) begin
			cnt <= 8'h00;
		end else if (cnt >= lag) begin
			trigger_in <= want;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule // lstw_instr

// ### tb/lstw_monitor.sv
// Port checker for the list step timing block
`timescale 1ns/100ps
module lstw_monitor #(
	parameter FILTER_CYC = 8
) (
	input wire clk_sys,
	input wire rstn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire trigger_in,
	input wire output_off_flag,
	input wire flag_transistor_on,
	input wire step_done
);
	// ********
	// Shadow of settings, taken early at the address handshake
	// ********
	reg [1:0] kind;
	reg run, duty, pol, d1, d2, d3, tp;
	reg [19:0] tmo, pw;
	reg [15:0] stab, hi, sc;
	wire aw = s_axi_awvalid & s_axi_awready;
	wire [3:0] wa = s_axi_awaddr[5:2];
	wire act = pol ? flag_transistor_on : !flag_transistor_on;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{kind, run, duty, pol, d1, d2, d3, tp} <= 9'h0;
			{tmo, pw, stab, hi, sc} <= 88'h0;
		end else begin
			// Delayed duty covers the write latency of the register side
			{d1, d2, d3, tp} <= {duty, d1, d2, trigger_in};
			stab <= (trigger_in != tp) ? 16'h0 : stab + 16'h1;
			hi <= act ? hi + 16'h1 : 16'h0;
			sc <= sc + 16'h1;
			if (step_done) run <= 1'b0;
			if (aw && wa == 4'h4) begin
				kind <= s_axi_wdata[1:0];
				run <= 1'b1;
				sc <= 16'h0;
			end
			if (aw && wa == 4'h3) tmo <= s_axi_wdata[19:0];
			if (aw && wa == 4'h2) {duty, pol, pw} <= {1'b1, s_axi_wdata[31], s_axi_wdata[19:0]};
			if (aw && wa == 4'h0 && s_axi_wdata[0]) {duty, tmo} <= 21'h0;
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_hold_low;
		run && kind == 2'h1 && !trigger_in;
	endsequence
	sequence s_pulse_end;
		$fell(act) && d3 && kind == 2'h3 && (run || $past(run));
	endsequence
	property p_high_wait;
		step_done && kind == 2'h1 && tmo == 20'h0 |-> trigger_in && stab >= FILTER_CYC;
	endproperty
	a_high_wait: assert property (p_high_wait) else $error("wait high end");
	property p_low_only;
		step_done && kind == 2'h2 |-> !trigger_in && stab >= FILTER_CYC;
	endproperty
	a_low_only: assert property (p_low_only) else $error("wait low end");
	property p_tmo_early;
		step_done && kind == 2'h1 && !trigger_in |-> sc >= tmo;
	endproperty
	a_tmo_early: assert property (p_tmo_early) else $error("timeout early");
	property p_tmo_bound;
		s_hold_low and tmo != 20'h0 |-> sc <= tmo + 20'd8;
	endproperty
	a_tmo_bound: assert property (p_tmo_bound) else $error("timeout late");
	property p_pulse_w;
		s_pulse_end |-> hi == pw;
	endproperty
	a_pulse_w: assert property (p_pulse_w) else $error("pulse width");
	property p_pulse_off;
		d3 && !pol && !run && !$past(run, 2) |-> flag_transistor_on;
	endproperty
	a_pulse_off: assert property (p_pulse_off) else $error("idle level");
	property p_flag_pass;
		!duty && !d3 && $past(rstn) && $stable(output_off_flag) |-> flag_transistor_on == output_off_flag;
	endproperty
	a_flag_pass: assert property (p_flag_pass) else $error("flag pass");
	property p_done_pulse;
		step_done |=> !step_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse");
endmodule // lstw_monitor

// ### tb/lstw_top_tb.sv
// Self-checking bench for the list step timing block
`timescale 1ns/100ps
`include "lstw_defines.vh"
module lstw_top_tb;
	reg clk_sys = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, want = 1'b0, off = 1'b0;
	reg [7:0] awa = 8'h00, ara = 8'h00, lag = 8'h03;
	reg brdy = 1'b0, rrdy = 1'b0;
	reg [1:0] bx = 2'h0;
	wire [1:0] br;
	wire flag;
	reg [31:0] wd = 32'h0;
	reg [19:0] w;
	reg [33:0] e;
	reg [33:0] q[$];
	wire awr, wrd, bv, arr, rv, trig, done;
	wire [1:0] rr;
	wire [31:0] rdat;
	integer failures = 0, tests_run = 0, cyc = 0, dones = 0, seed = 86;
	lstw_top #(.FILTER_CYC(8), .CYC_MIN(2), .CYC_MAX(1000)) lstw_top_i (.clk_sys(clk_sys),
		.rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy), .trigger_in(trig), .output_off_flag(off),
		.flag_transistor_on(flag), .step_done(done));
	lstw_instr lstw_instr_i (.clk_sys(clk_sys), .want(want), .lag(lag), .trigger_in(trig));
	initial forever #50 clk_sys = ~clk_sys;
	task chk(input [33:0] g, input [33:0] x);
		begin
			tests_run = tests_run + 1;
			if (g !== x) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	task wrap_up;
		begin
			if (failures == 0 && tests_run > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	// Response readies rise with each request and drop one edge after the answer
	task wr(input [7:0] a, input [31:0] d);
		reg pa, pd;
		begin
			q.push_back({bx, 32'h0});
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			brdy <= 1'b1;
			pa = 1'b1;
			pd = 1'b1;
			while (pa | pd) begin
				@(posedge clk_sys);
				if (awr) pa = 1'b0;
				if (wrd) pd = 1'b0;
				if (!pa) awv <= 1'b0;
				if (!pd) wv <= 1'b0;
			end
			while (!bv) @(posedge clk_sys);
			brdy <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rd(input [7:0] a, input [33:0] x);
		begin
			q.push_back(x);
			ara <= a;
			arv <= 1'b1;
			rrdy <= 1'b1;
			@(posedge clk_sys);
			while (!arr) @(posedge clk_sys);
			arv <= 1'b0;
			@(posedge clk_sys);
			while (!rv) @(posedge clk_sys);
			rrdy <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task step(input [1:0] k);
		integer n;
		begin
			n = dones;
			wr(`LSTW_REG_STEP, {30'h0, k});
			while (dones == n) @(posedge clk_sys);
		end
	endtask
	task hold(input [1:0] k, input lvl);
		integer n;
		begin
			n = dones;
			wr(`LSTW_REG_STEP, {30'h0, k});
			repeat (30) @(posedge clk_sys);
			chk(34'(dones - n), 34'h0);
			want <= lvl;
			while (dones == n) @(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys) begin
		if ((rv && rrdy) || (bv && brdy)) begin
			e = q.pop_front();
			chk(rv ? {rr, rdat} : {br, 32'h0}, e);
		end
		if (done === 1'b1) dones = dones + 1;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(`LSTW_REG_WAIT, 34'h0);
		rd(`LSTW_REG_SAMP, 34'h0);
		rd(`LSTW_REG_ERR, 34'h164);
		wr(`LSTW_REG_ERR, 32'h0);
		rd(`LSTW_REG_PULSE, 34'h0);
		rd(`LSTW_REG_ERR, 34'h164);
		wr(`LSTW_REG_ERR, 32'h0);
		wr(`LSTW_REG_STEP, 32'h3);
		rd(`LSTW_REG_ERR, 34'h1dd);
		wr(`LSTW_REG_SAMP, 32'd1001);
		rd(`LSTW_REG_ERR, 34'h164);
		wr(`LSTW_REG_ERR, 32'h0);
		w = 20'd2 + 20'({$random(seed)} % 999);
		wr(`LSTW_REG_SAMP, {12'h0, w});
		wr(`LSTW_REG_SAMP, 32'd5);
		rd(`LSTW_REG_SAMP, {14'h0, w});
		rd(`LSTW_REG_ERR, 34'h164);
		w = 20'd2 + 20'({$random(seed)} % 40);
		wr(`LSTW_REG_PULSE, {12'h800, w});
		rd(`LSTW_REG_PULSE, {14'h800, w});
		rd(`LSTW_REG_CTRL, 34'h1);
		step(2'h3);
		wr(`LSTW_REG_WAIT, 32'd20);
		rd(`LSTW_REG_WAIT, 34'd20);
		step(2'h1);
		step(2'h1);
		wr(`LSTW_REG_CTRL, 32'h1);
		off <= 1'($random(seed));
		rd(`LSTW_REG_CTRL, 34'h0);
		rd(`LSTW_REG_WAIT, 34'h0);
		chk({33'h0, flag}, {33'h0, off});
		repeat (2) begin
			lag <= {2'h0, 6'($random(seed))};
			hold(2'h1, 1'b1);
			hold(2'h2, 1'b0);
		end
		wr(`LSTW_REG_PULSE, {12'h0, w});
		chk({33'h0, flag}, 34'h1);
		step(2'h3);
		bx = 2'h2;
		wr(8'h40, 32'h0);
		bx = 2'h0;
		rd(8'h40, 34'h200000000);
		wrap_up;
	end
endmodule // lstw_top_tb
bind lstw_top lstw_monitor #(.FILTER_CYC(FILTER_CYC)) lstw_monitor_i (.clk_sys(clk_sys),
	.rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .trigger_in(trigger_in),
	.output_off_flag(output_off_flag), .flag_transistor_on(flag_transistor_on),
	.step_done(step_done));
